// file: inc/upc_consts.vh
// Register map, field positions, reset values and mode codes of the user pin block
`ifndef UPC_CONSTS_VH
`define UPC_CONSTS_VH
// ============================================================
// Register offsets (byte addresses on the plain register port)
`define UPC_ADDR_PIN1      4'h0
`define UPC_ADDR_PIN2      4'h1
`define UPC_ADDR_PIN3      4'h2
`define UPC_ADDR_STATUS    4'h3
`define UPC_ADDR_NORMAL    4'h4
`define UPC_ADDR_SLEEP     4'h5
// ============================================================
// Pin control register fields
`define UPC_MODE_HI        7
`define UPC_MODE_LO        4
`define UPC_PULLUP_BIT     3
`define UPC_SUPPLY_BIT     2
`define UPC_POL_BIT        1
`define UPC_LEVEL_BIT      0
`define UPC_CFG_RESET      8'h08
// ============================================================
// Mode codes
`define UPC_MD_GPI         4'h0
`define UPC_MD_GPO         4'h1
`define UPC_MD_SWA         4'h2
`define UPC_MD_SWB         4'h3
`define UPC_MD_CHANGEOVER_SWITCH_ONE       4'h4
`define UPC_MD_CHANGEOVER_SWITCH_TWO       4'h5
`define UPC_MD_SLEEP       4'h6
`define UPC_MD_WAKE        4'h7
`define UPC_MD_PWM         4'hb
`define UPC_MD_SHUTDOWN_FLAG        4'hc
`define UPC_MD_ALARM       4'hd
`define UPC_MD_CONVERSION_DONE        4'hf
`endif

// file: hdl/upc_pin_ctrl.v
// One user pin: mode decode, output drive, pull-up and input assertion
`include "upc_consts.vh"
module upc_pin_ctrl (
    input  wire [7:0] cfg,
    input  wire       pin_in,
    input  wire       pwm_level,
    input  wire       pwm_enable,
    input  wire       shutdown_flag,
    input  wire       day_alarm_status,
    input  wire       conversion_done,
    output reg        drv_out,
    output reg        drv_oe,
    output wire       pullup_on,
    output wire       supply_sel,
    output wire [5:0] func_assert
);
    wire [3:0] mode   = cfg[`UPC_MODE_HI:`UPC_MODE_LO];
    wire       pol_hi = cfg[`UPC_POL_BIT];
    // Input function asserted per polarity
    wire       asrt   = pol_hi ? pin_in : ~pin_in; // R7
    wire       is_in  = (mode == `UPC_MD_GPI) || (mode >= `UPC_MD_SWA && mode <= `UPC_MD_WAKE);

    assign pullup_on  = cfg[`UPC_PULLUP_BIT] & is_in; // R5
    assign supply_sel = cfg[`UPC_SUPPLY_BIT]; // R6
    // Order: swa, swb, changeover_switch_one, changeover_switch_two, sleep, wake
    assign func_assert = {
        (mode == `UPC_MD_WAKE)  & asrt,
        (mode == `UPC_MD_SLEEP) & asrt,
        (mode == `UPC_MD_CHANGEOVER_SWITCH_TWO) & asrt,
        (mode == `UPC_MD_CHANGEOVER_SWITCH_ONE) & asrt,
        (mode == `UPC_MD_SWB)   & asrt,
        (mode == `UPC_MD_SWA)   & asrt}; // R8 R9 R10 R11

    always @* begin
        drv_oe  = 1'b1;
        drv_out = 1'b0;
        case (mode)
            `UPC_MD_GPO:   drv_out = cfg[`UPC_LEVEL_BIT]; // R3
            // A stopped generator parks the pin at the polarity level itself
            `UPC_MD_PWM:   drv_out = pwm_enable ? (pwm_level ~^ pol_hi) : pol_hi; // R13
            `UPC_MD_SHUTDOWN_FLAG:  drv_out = shutdown_flag ~^ pol_hi; // R14
            `UPC_MD_ALARM: drv_out = day_alarm_status ~^ pol_hi; // R15
            `UPC_MD_CONVERSION_DONE:  drv_out = conversion_done ~^ pol_hi; // R16
            default:       drv_oe  = 1'b0;
        endcase
    end
endmodule

// file: hdl/upc_edge_det.v
// Rising and falling edge detector for one synchronous input
module upc_edge_det (
    input  wire clk_sys,
    input  wire srst,
    input  wire ce,
    input  wire din,
    output wire rise,
    output wire fall
);
    reg prev_ff;
    always @(posedge clk_sys) begin
        if (srst) begin
            // Pull-up idle level, so a pulled-up pin shows no false edge after reset
            prev_ff <= 1'b1;
        end else if (ce) begin
            prev_ff <= din;
        end
    end
    assign rise = ce & din & ~prev_ff;
    assign fall = ce & ~din & prev_ff;
endmodule

// file: hdl/upc_user_pin.v
// Top of the user pin configuration block: registers, pin drive and shutdown control
// Function
// R1: Each pin has a 4-bit mode field resetting to zero, general input.
// R2: General input reports edges on rising and falling flags, ignores polarity.
// R3: General output drives the pin from the level bit, polarity ignored.
// R4: Reading the level bit returns the live pin level.
// R5: Pull-up is on when enabled and the pin is an input; resets on.
// R6: Supply select picks main or pump supply in every mode; resets main.
// R7: Polarity bit sets active low or high for special modes.
// R8: Modes 2 and 3 feed DAC A and DAC B switch control.
// R9: Modes 4 and 5 feed the two changeover switch controls.
// R10: Asserted sleep input forces sleep; otherwise shutdown flag decides.
// R11: Asserting edge of a wake input clears the shutdown flag.
// R12: Software must not write reserved mode codes.
// R13: PWM mode carries the pulse output; idles at polarity level when disabled.
// R14: Shutdown output mode shows the shutdown flag with the selected polarity.
// R15: Day alarm output mode mirrors the day alarm status.
// R16: Data ready output asserts on conversion done, unaffected by the mask bit.
// R17: Each pin control register resets to 08 hex.
// R18: Open-drain is emulated by software toggling output low and pulled-off input.
// R19: Several pins with the same input function are ORed.
// R20: Shutdown clears on normal-mode write, day alarm or wake edge.
// R21: Each pin register acts on its own pin only.
// R22: Writes take effect at once; reads return fields with live level.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "upc_consts.vh"
module upc_user_pin #(
    parameter NPIN = 3
) (
    input  wire            clk_sys,
    input  wire            srst,
    input  wire            ce,
    input  wire [3:0]      reg_addr,
    input  wire [7:0]      reg_wdata,
    input  wire            reg_wr,
    input  wire            reg_rd,
    output reg  [7:0]      reg_rdata,
    input  wire [NPIN-1:0] pin_in,
    output reg  [NPIN-1:0] pin_out,
    output reg  [NPIN-1:0] pin_oe,
    output reg  [NPIN-1:0] pin_pullup,
    output reg  [NPIN-1:0] pin_supply_sel,
    input  wire            pwm_level,
    input  wire            pulse_width_enable,
    input  wire            day_alarm_status,
    input  wire            conversion_done,
    output reg             dac_a_switch,
    output reg             dac_b_switch,
    output reg             changeover_switch_one,
    output reg             changeover_switch_two,
    output reg             sleep_active,
    output reg             shutdown_flag
);
    // ============================================================
    // Registers
    reg  [7:0]      cfg_ff [0:NPIN-1];
    reg  [NPIN-1:0] rising_edge_flag_ff;
    reg  [NPIN-1:0] falling_edge_flag_ff;
    reg             shutdown_flag_ff;
    reg             alarm_prev_ff;
    wire [NPIN-1:0] rise;
    wire [NPIN-1:0] fall;
    wire [NPIN-1:0] drv_out;
    wire [NPIN-1:0] drv_oe;
    wire [NPIN-1:0] pull_on;
    wire [NPIN-1:0] sup_sel;
    wire [NPIN-1:0] f_swa;
    wire [NPIN-1:0] f_swb;
    wire [NPIN-1:0] f_sp1;
    wire [NPIN-1:0] f_sp2;
    wire [NPIN-1:0] f_slp;
    wire [NPIN-1:0] f_wake;
    wire [NPIN-1:0] wake_edge;
    wire [NPIN-1:0] gpi_sel;
    wire [NPIN-1:0] rd_sel;
    wire            wr_sel_status;
    wire            wr_norm;
    wire            wr_sleep;
    wire            alarm_rise;
    reg  [7:0]      nxt_rdata;
    integer         k;
    integer         kf;
    integer         kr;

    // ============================================================
    // Per-pin logic
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            wire [5:0] fa;
            reg        wake_prev_ff;
            upc_pin_ctrl u_ctrl (
                .cfg              (cfg_ff[g]),
                .pin_in           (pin_in[g]),
                .pwm_level        (pwm_level),
                .pwm_enable       (pulse_width_enable),
                .shutdown_flag    (shutdown_flag_ff),
                .day_alarm_status (day_alarm_status),
                .conversion_done  (conversion_done),
                .drv_out          (drv_out[g]),
                .drv_oe           (drv_oe[g]),
                .pullup_on        (pull_on[g]),
                .supply_sel       (sup_sel[g]),
                .func_assert      (fa)
            ); // R21
            upc_edge_det u_edge (
                .clk_sys (clk_sys),
                .srst    (srst),
                .ce      (ce),
                .din     (pin_in[g]),
                .rise    (rise[g]),
                .fall    (fall[g])
            );
            assign f_swa[g]  = fa[0];
            assign f_swb[g]  = fa[1];
            assign f_sp1[g]  = fa[2];
            assign f_sp2[g]  = fa[3];
            assign f_slp[g]  = fa[4];
            assign f_wake[g] = fa[5];
            // Wake edge is the rising edge of the asserted state
            always @(posedge clk_sys) begin
                if (srst) begin
                    wake_prev_ff <= 1'b0;
                end else if (ce) begin
                    wake_prev_ff <= fa[5];
                end
            end
            assign wake_edge[g] = ce & fa[5] & ~wake_prev_ff; // R11
            assign gpi_sel[g]   = (cfg_ff[g][`UPC_MODE_HI:`UPC_MODE_LO] == `UPC_MD_GPI);
            assign rd_sel[g]    = ({28'h0000000, reg_addr} == g);
        end
    endgenerate

    // ============================================================
    // Register decode
    assign wr_sel_status = reg_wr && (reg_addr == `UPC_ADDR_STATUS);
    assign wr_norm       = reg_wr && (reg_addr == `UPC_ADDR_NORMAL);
    assign wr_sleep      = reg_wr && (reg_addr == `UPC_ADDR_SLEEP);
    assign alarm_rise    = day_alarm_status & ~alarm_prev_ff;

    always @(posedge clk_sys) begin
        if (srst) begin
            for (k = 0; k < NPIN; k = k + 1) begin
                cfg_ff[k] <= `UPC_CFG_RESET; // R1 R17
            end
        end else if (ce && reg_wr) begin
            for (k = 0; k < NPIN; k = k + 1) begin
                if (reg_addr == k[3:0]) begin
                    cfg_ff[k] <= reg_wdata; // R22
                end
            end
        end
    end

    // ============================================================
    // Edge status flags: write one to clear, a new edge wins
    always @(posedge clk_sys) begin
        if (srst) begin
            rising_edge_flag_ff  <= {NPIN{1'b0}};
            falling_edge_flag_ff <= {NPIN{1'b0}};
        end else if (ce) begin
            for (kf = 0; kf < NPIN; kf = kf + 1) begin
                if (gpi_sel[kf] && rise[kf]) begin
                    rising_edge_flag_ff[kf] <= 1'b1; // R2
                end else if (wr_sel_status && reg_wdata[kf]) begin
                    rising_edge_flag_ff[kf] <= 1'b0;
                end
                if (gpi_sel[kf] && fall[kf]) begin
                    falling_edge_flag_ff[kf] <= 1'b1; // R2
                end else if (wr_sel_status && reg_wdata[kf+4]) begin
                    falling_edge_flag_ff[kf] <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // Shutdown flag: a sleep write sets it; clearing events yield to it
    always @(posedge clk_sys) begin
        if (srst) begin
            shutdown_flag_ff       <= 1'b0;
            alarm_prev_ff <= 1'b0;
        end else if (ce) begin
            alarm_prev_ff <= day_alarm_status;
            if (wr_sleep) begin
                shutdown_flag_ff <= 1'b1;
            end else if (wr_norm || alarm_rise || (|wake_edge)) begin
                shutdown_flag_ff <= 1'b0; // R20
            end
        end
    end

    // ============================================================
    // Read path and registered outputs
    always @* begin
        nxt_rdata = 8'h00;
        for (kr = 0; kr < NPIN; kr = kr + 1) begin
            if (rd_sel[kr]) begin
                nxt_rdata = {cfg_ff[kr][7:1], pin_in[kr]}; // R4 R22
            end
        end
        if (reg_addr == `UPC_ADDR_STATUS) begin
            nxt_rdata = 8'h00;
            nxt_rdata[NPIN-1:0]   = rising_edge_flag_ff;
            nxt_rdata[NPIN+3:4]   = falling_edge_flag_ff;
        end
        if (reg_addr == `UPC_ADDR_SLEEP) begin
            nxt_rdata = {7'h00, shutdown_flag_ff};
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata             <= 8'h00;
            pin_out               <= {NPIN{1'b0}};
            pin_oe                <= {NPIN{1'b0}};
            pin_pullup            <= {NPIN{1'b1}};
            pin_supply_sel        <= {NPIN{1'b0}};
            dac_a_switch          <= 1'b0;
            dac_b_switch          <= 1'b0;
            changeover_switch_one <= 1'b0;
            changeover_switch_two <= 1'b0;
            sleep_active          <= 1'b0;
            shutdown_flag         <= 1'b0;
        end else if (ce) begin
            reg_rdata             <= reg_rd ? nxt_rdata : 8'h00;
            pin_out               <= drv_out; // R3 R13 R14 R15 R16
            pin_oe                <= drv_oe;
            pin_pullup            <= pull_on; // R5
            pin_supply_sel        <= sup_sel; // R6
            dac_a_switch          <= |f_swa; // R8 R19
            dac_b_switch          <= |f_swb; // R8 R19
            changeover_switch_one <= |f_sp1; // R9 R19
            changeover_switch_two <= |f_sp2; // R9 R19
            sleep_active          <= (|f_slp) | shutdown_flag_ff; // R10 R19
            shutdown_flag         <= shutdown_flag_ff;
        end
    end
endmodule

// file: testbench/upc_pin_partner.sv
// External devices seen by the user pins
module upc_pin_partner (
    input  logic       clk_sys,
    input  logic [2:0] pin_out,
    input  logic [2:0] pin_oe,
    input  logic [2:0] pin_pullup,
    input  logic [2:0] ext_en,
    input  logic [2:0] ext_lvl,
    output logic [2:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] tgl_ff = 3'h0;
    // A floating pin without pull-up toggles so that a stale level is never read back as valid; a pulled-up one reads high
    always @(posedge clk_sys) tgl_ff <= ~tgl_ff;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                  | (~pin_oe & ~ext_en & (pin_pullup | tgl_ff));
endmodule

// file: testbench/upc_user_pin_chk.sv
// Port assertions of the user pin block
module upc_user_pin_chk #(
    parameter NPIN = 3
) (
    input wire            clk_sys,
    input wire            srst,
    input wire [3:0]      reg_addr,
    input wire            reg_wr,
    input wire            reg_rd,
    input wire [7:0]      reg_rdata,
    input wire [NPIN-1:0] pin_in,
    input wire [NPIN-1:0] pin_oe,
    input wire [NPIN-1:0] pin_pullup,
    input wire            day_alarm_status,
    input wire            sleep_active,
    input wire            shutdown_flag
);
    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_read_level: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[0] == $past(pin_in[0]))
        else $error("level bit not live");
    chk_unmapped_read: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_pullup_input: assert property ((pin_oe & pin_pullup) == {NPIN{1'b0}})
        else $error("pull-up on a driven pin");
    chk_reset_values: assert property ($past(srst) |-> pin_oe == {NPIN{1'b0}} && pin_pullup == {NPIN{1'b1}} && !shutdown_flag)
        else $error("bad state after reset");
    chk_sleep_write: assert property (reg_wr && reg_addr == 4'h5 |-> ##[1:2] shutdown_flag)
        else $error("shutdown not set");
    chk_normal_write: assert property (reg_wr && reg_addr == 4'h4 |-> ##[1:2] !shutdown_flag)
        else $error("shutdown not cleared by write");
    chk_alarm_wake: assert property ($rose(day_alarm_status) && !reg_wr |-> ##[1:2] !shutdown_flag)
        else $error("shutdown not cleared by alarm");
    chk_sleep_follow: assert property (shutdown_flag [*2] |-> sleep_active)
        else $error("sleep not following shutdown");
    cover property (reg_wr && reg_addr == 4'h0);
    cover property ($fell(shutdown_flag));
    cover property (pin_oe != {NPIN{1'b0}});
endmodule

// file: testbench/testbench.sv
// Self-checking bench of the user pin block against a behavioural model
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Signals and model state
    logic       clk_sys = 1'h0;
    logic       ce = 1'h1;
    logic       srst = 1'h1;
    logic       reg_wr = 1'h0;
    logic       reg_rd = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [2:0] pin_in, pin_out, pin_oe, pin_pullup, pin_supply_sel;
    logic [2:0] ext_lvl = 3'h0;
    logic       pwm_level = 1'h0;
    logic       pulse_width_enable = 1'h0;
    logic       day_alarm_status = 1'h0;
    logic       conversion_done = 1'h0;
    logic       sw_a, sw_b, sw_1, sw_2, sleep_active, shutdown_flag;
    logic [7:0] cfg_m [3] = '{8'h08, 8'h08, 8'h08};
    logic       sd_m = 1'h0;
    logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hb, 4'hc, 4'hd, 4'hf};
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         cyc = 0;
    upc_user_pin #(.NPIN(3)) i_upc_user_pin (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_supply_sel(pin_supply_sel), .pwm_level(pwm_level),
        .pulse_width_enable(pulse_width_enable), .day_alarm_status(day_alarm_status),
        .conversion_done(conversion_done), .dac_a_switch(sw_a), .dac_b_switch(sw_b),
        .changeover_switch_one(sw_1), .changeover_switch_two(sw_2),
        .sleep_active(sleep_active), .shutdown_flag(shutdown_flag));
    upc_pin_partner i_upc_pin_partner (
        .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(3'h7), .ext_lvl(ext_lvl), .pin_in(pin_in));
    // ============================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= 1'h0;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp, "read");
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge clk_sys);
    endtask
    function automatic logic [1:0] drv(input logic [7:0] c);
        case (c[7:4])
            4'h1: return {1'h1, c[0]};
            4'hb: return {1'h1, pulse_width_enable ? ~(pwm_level ^ c[1]) : c[1]};
            4'hc: return {1'h1, ~(sd_m ^ c[1])};
            4'hd: return {1'h1, ~(day_alarm_status ^ c[1])};
            4'hf: return {1'h1, ~(conversion_done ^ c[1])};
            default: return 2'h0;
        endcase
    endfunction
    task automatic check_all();
        logic [2:0] oe, out, pu, sv, lv;
        logic [4:0] fn;
        logic [1:0] d;
        fn = 5'h00;
        for (int i = 0; i < 3; i++) begin
            d = drv(cfg_m[i]);
            {oe[i], out[i]} = d;
            pu[i] = cfg_m[i][3] & ~d[1];
            sv[i] = cfg_m[i][2];
            lv[i] = d[1] ? d[0] : ext_lvl[i];
            if (cfg_m[i][7:4] inside {[4'h2:4'h6]})
                fn[cfg_m[i][7:4] - 4'h2] |= ~(lv[i] ^ cfg_m[i][1]);
        end
        #1 chk({pin_oe, pin_out & pin_oe, pin_pullup, pin_supply_sel}, {oe, out & oe, pu, sv}, "pins");
        chk({sw_a, sw_b, sw_1, sw_2, sleep_active, shutdown_flag},
            {fn[0], fn[1], fn[2], fn[3], sd_m | fn[4], sd_m}, "func");
        for (int i = 0; i < 3; i++) rd(4'(i), {cfg_m[i][7:1], lv[i]});
        rd(4'hf, 8'h00);
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ============================================================
    // Clock, watchdog and sequence
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        logic na;
        void'($urandom(73));
        repeat (16) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        check_all();
        repeat (40) begin
            na = 1'($urandom);
            if (na && !day_alarm_status) sd_m = 1'h0;
            day_alarm_status <= na;
            pwm_level <= 1'($urandom);
            pulse_width_enable <= 1'($urandom);
            conversion_done <= 1'($urandom);
            ext_lvl <= 3'($urandom);
            // Two idle cycles keep the alarm clear apart from the next shutdown write
            idle(2);
            sd_m = 1'($urandom);
            wr(sd_m ? 4'h5 : 4'h4, 8'h00);
            for (int i = 0; i < 3; i++) begin
                cfg_m[i] = {modes[$urandom % 11], 4'($urandom)};
                wr(4'(i), cfg_m[i]);
            end
            wr(4'h9, 8'hff);
            idle(4);
            check_all();
        end
        for (int i = 0; i < 3; i++) wr(4'(i), 8'h0a);
        ext_lvl <= 3'h0;
        idle(3);
        wr(4'h3, 8'h77);
        ext_lvl <= 3'h1;
        idle(3);
        rd(4'h3, 8'h01);
        wr(4'h3, 8'h77);
        ext_lvl <= 3'h0;
        idle(3);
        rd(4'h3, 8'h10);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h7a);
        idle(3);
        ext_lvl <= 3'h2;
        idle(3);
        #1 chk(shutdown_flag, 1'h0, "wake high");
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h78);
        idle(3);
        #1 chk(shutdown_flag, 1'h1, "wake idle");
        ext_lvl <= 3'h0;
        idle(3);
        #1 chk(shutdown_flag, 1'h0, "wake low");
        // A write while the clock enable is low must leave the register untouched
        ce <= 1'h0;
        wr(4'h0, 8'h18);
        idle(2);
        ce <= 1'h1;
        rd(4'h0, 8'h0a);
        final_report();
    end
endmodule
bind upc_user_pin upc_user_pin_chk #(.NPIN(NPIN)) i_upc_user_pin_chk (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .day_alarm_status(day_alarm_status),
    .sleep_active(sleep_active), .shutdown_flag(shutdown_flag));
